// ### bench/flash_cmd_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// port checker
module flash_cmd_unit_properties #(
   parameter int WRITE_PAGE_CYCLES = 50,
   parameter int ERASE_CYCLES = 60,
   parameter int UPD_WRITE_PAGE_CYCLES = 400
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register access
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // core control
   input wire logic core_stall,
   input wire logic irq_hold,
   input wire logic update_mode,
   // far side
   input wire logic [7:0] internal_extended_ram_addr,
   input wire logic [7:0] internal_extended_ram_rdata,
   input wire flash_cmd_pkg::pm_req_t pm_req
);
   import flash_cmd_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire logic cmd_wr;
   wire logic pm_any;
   assign cmd_wr = sfr_wr && sfr_addr == ADDR_CMD && !core_stall;
   assign pm_any = pm_req.we || pm_req.erase_page || pm_req.erase_all;
   property p_irq; irq_hold == core_stall; endproperty
   a_irq: assert property (p_irq) else $error("irq hold differs from stall");
   property p_rd_len;
      cmd_wr && sfr_wdata == CMD_READ_PAGE && !update_mode |=> core_stall [*8] ##[10:24] !core_stall;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("page read stall length wrong");
   property p_enter; cmd_wr && sfr_wdata == CMD_ENTER_UPDATE |-> ##[1:3] update_mode; endproperty
   a_enter: assert property (p_enter) else $error("update mode not entered");
   property p_leave; cmd_wr && sfr_wdata == CMD_LEAVE_UPDATE |-> ##[1:3] !update_mode; endproperty
   a_leave: assert property (p_leave) else $error("normal mode not entered");
   property p_refuse; cmd_wr && sfr_wdata == 8'h03 |=> !core_stall && !pm_any; endproperty
   a_refuse: assert property (p_refuse) else $error("reserved code started work");
   property p_unimpl;
      cmd_wr && update_mode && (sfr_wdata == CMD_READ_PAGE || sfr_wdata == CMD_READ_BYTE) |=> !core_stall;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented code stalled");
   property p_pm_mode; pm_any |-> update_mode && core_stall && pm_req.addr <= UPD_BYTE_MAX; endproperty
   a_pm_mode: assert property (p_pm_mode) else $error("program memory touched out of range");
   property p_align; pm_req.erase_page |-> pm_req.addr[5:0] == 6'h00; endproperty
   a_align: assert property (p_align) else $error("erase page not aligned");
   property p_pulse; pm_req.erase_all |=> !pm_req.erase_all; endproperty
   a_pulse: assert property (p_pulse) else $error("erase all longer than one cycle");
   c_read: cover property (cmd_wr && sfr_wdata == CMD_READ_PAGE);
   c_update: cover property (cmd_wr && sfr_wdata == CMD_ENTER_UPDATE);
   c_stream: cover property (pm_req.we ##1 pm_req.we);
endmodule
bind flash_data_memory_command_unit flash_cmd_unit_properties #(
   .WRITE_PAGE_CYCLES(WRITE_PAGE_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES),
   .UPD_WRITE_PAGE_CYCLES(UPD_WRITE_PAGE_CYCLES)
) flash_cmd_unit_properties_i (.clock(clock), .arst_n(arst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .core_stall(core_stall), .irq_hold(irq_hold),
   .update_mode(update_mode), .internal_extended_ram_addr(internal_extended_ram_addr), .internal_extended_ram_rdata(internal_extended_ram_rdata), .pm_req(pm_req));
`default_nettype wire

// ### bench/flash_data_memory_command_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("BAD %s %h %h", nm, e, g); end end
module flash_data_memory_command_unit_test;
   import flash_cmd_pkg::*;
   localparam int WP = 50;
   localparam int ERA = 60;
   localparam int UWP = 400;
   logic clock, arst_n, sfr_wr, core_stall, irq_hold, update_mode;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, internal_extended_ram_addr, internal_extended_ram_rdata, b;
   logic [15:0] last_addr;
   logic [7:0] last_wdata;
   pm_req_t pm_req;
   int num_errors, tests_run, cycles, n, we_cnt, ep_cnt, ea_cnt;
   flash_data_memory_command_unit #(.WRITE_PAGE_CYCLES(WP), .ERASE_CYCLES(ERA), .UPD_WRITE_PAGE_CYCLES(UWP))
      flash_data_memory_command_unit_i (.clock(clock), .arst_n(arst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .core_stall(core_stall), .irq_hold(irq_hold),
      .update_mode(update_mode), .internal_extended_ram_addr(internal_extended_ram_addr), .internal_extended_ram_rdata(internal_extended_ram_rdata), .pm_req(pm_req));
   flash_pm_model flash_pm_model_i (.clock(clock), .arst_n(arst_n), .internal_extended_ram_addr(internal_extended_ram_addr),
      .internal_extended_ram_rdata(internal_extended_ram_rdata), .pm_req(pm_req), .we_cnt(we_cnt), .erase_page_cnt(ep_cnt),
      .erase_all_cnt(ea_cnt), .last_addr(last_addr), .last_wdata(last_wdata));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask
   // n counts stalled cycles
   task automatic cmd(input logic [7:0] c);
      wr(ADDR_CMD, c);
      #1;
      n = 0;
      while (core_stall === 1'b1 && n < 5000) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      @(negedge clock);
      d = sfr_rdata;
   endtask
   task automatic setadr(input logic [15:0] a);
      wr(ADDR_ADR_HIGH, a[15:8]);
      wr(ADDR_ADR_LOW, a[7:0]);
   endtask
   task automatic setdat(input logic [31:0] v);
      wr(ADDR_DATA_ONE, v[31:24]);
      wr(ADDR_DATA_TWO, v[23:16]);
      wr(ADDR_DATA_THREE, v[15:8]);
      wr(ADDR_DATA_FOUR, v[7:0]);
   endtask
   task automatic chkdat(input string nm, input logic [31:0] e);
      logic [7:0] b1, b2, b3, b4;
      rd(ADDR_DATA_ONE, b1);
      rd(ADDR_DATA_TWO, b2);
      rd(ADDR_DATA_THREE, b3);
      rd(ADDR_DATA_FOUR, b4);
      `CHK(nm, e, {b1, b2, b3, b4})
   endtask
   initial begin
      arst_n = 1'b0;
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      num_errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      rd(ADDR_CMD, b);
      `CHK("cmd reset", CMD_RESET, b)
      `CHK("reset mode", 1'b0, update_mode)
      cmd(CMD_ERASE_ALL);
      `CHK("erase len", 1'b1, n >= ERA - 1 && n <= ERA + 2)
      setadr(16'h0003);
      cmd(CMD_READ_PAGE);
      `CHK("read len", 1'b1, n >= 24 && n <= 27)
      chkdat("erased", 32'hFFFF_FFFF);
      setdat(32'h11F3_3344);
      cmd(CMD_WRITE_PAGE);
      `CHK("write len", 1'b1, n >= WP - 1 && n <= WP + 2)
      setdat(32'h0000_0000);
      cmd(CMD_READ_PAGE);
      chkdat("page3", 32'h11F3_3344);
      cmd(CMD_VERIFY_PAGE);
      rd(ADDR_CMD, b);
      `CHK("verify ok", 8'h00, b)
      wr(ADDR_DATA_TWO, 8'h00);
      cmd(CMD_VERIFY_PAGE);
      rd(ADDR_CMD, b);
      `CHK("verify bad", 1'b1, b != 8'h00)
      setadr(16'h000D);
      cmd(CMD_READ_BYTE);
      rd(ADDR_DATA_ONE, b);
      `CHK("read byte", 8'hF3, b)
      setadr(16'h0005);
      cmd(CMD_ERASE_PAGE);
      setadr(16'h0016);
      wr(ADDR_DATA_ONE, 8'hA5);
      cmd(CMD_WRITE_BYTE);
      setadr(16'h0005);
      cmd(CMD_READ_PAGE);
      chkdat("byte prog", 32'hFFFF_A5FF);
      cmd(8'h03);
      `CHK("reserved", 0, n)
      setadr(16'h0400);
      setdat(32'h0000_0000);
      cmd(CMD_WRITE_PAGE);
      setadr(16'h0000);
      cmd(CMD_READ_PAGE);
      chkdat("page0", 32'hFFFF_FFFF);
      setadr(16'h0003);
      cmd(CMD_READ_PAGE);
      chkdat("page3 kept", 32'h11F3_3344);
      cmd(CMD_ENTER_UPDATE);
      `CHK("update", 1'b1, update_mode)
      setdat(32'h0000_0000);
      cmd(CMD_READ_PAGE);
      `CHK("upd read", 0, n)
      chkdat("upd none", 32'h0000_0000);
      setadr(16'h1234);
      cmd(CMD_ERASE_PAGE);
      `CHK("pm erase", 17'h11200, {ep_cnt[0], last_addr})
      cmd(CMD_ERASE_ALL);
      `CHK("pm erase all", 1, ea_cnt)
      setadr(16'hDFFF);
      wr(ADDR_DATA_ONE, 8'h3C);
      cmd(CMD_WRITE_BYTE);
      `CHK("pm byte", 24'hDFFF3C, {last_addr, last_wdata})
      setadr(16'hE000);
      cmd(CMD_WRITE_BYTE);
      `CHK("pm limit", 1, we_cnt)
      setadr(16'h0010);
      cmd(CMD_WRITE_PAGE);
      `CHK("upd len", 1'b1, n >= UWP - 2 && n <= UWP + 3)
      `CHK("pm stream", 24'h10FFA5, {last_addr, last_wdata})
      `CHK("pm count", 257, we_cnt)
      setadr(16'h00E0);
      cmd(CMD_WRITE_PAGE);
      `CHK("pm page lim", 257, we_cnt)
      cmd(CMD_LEAVE_UPDATE);
      `CHK("normal", 1'b0, update_mode)
      end_sim();
   end
endmodule
`default_nettype wire

// ### bench/flash_pm_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// program memory and extended ram stand-in
module flash_pm_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // extended ram
   input wire logic [7:0] internal_extended_ram_addr,
   output logic [7:0] internal_extended_ram_rdata,
   // program memory
   input wire flash_cmd_pkg::pm_req_t pm_req,
   output int we_cnt,
   output int erase_page_cnt,
   output int erase_all_cnt,
   output logic [15:0] last_addr,
   output logic [7:0] last_wdata
);
   import flash_cmd_pkg::*;
   // pattern differs per address so a wrong stream index shows
   assign internal_extended_ram_rdata = internal_extended_ram_addr ^ 8'h5A;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         we_cnt <= 0;
         erase_page_cnt <= 0;
         erase_all_cnt <= 0;
         last_addr <= 16'h0000;
         last_wdata <= 8'h00;
      end else begin
         if (pm_req.we) begin
            we_cnt <= we_cnt + 1;
            last_addr <= pm_req.addr;
            last_wdata <= pm_req.wdata;
         end
         if (pm_req.erase_page) begin
            erase_page_cnt <= erase_page_cnt + 1;
            last_addr <= pm_req.addr;
         end
         if (pm_req.erase_all) begin
            erase_all_cnt <= erase_all_cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### verilog/flash_cmd_pkg.sv
package flash_cmd_pkg;
   // =====================================
   // clock and timing
   localparam int CLK_MHZ = 20;
   localparam int READ_PAGE_MC = 25;
   localparam int VERIFY_PAGE_MC = 25;
   localparam int READ_BYTE_MC = 10;
   localparam int WRITE_PAGE_US = 380;
   localparam int WRITE_BYTE_US = 200;
   localparam int ERASE_MS = 2;
   localparam int UPD_WRITE_PAGE_MS = 15;
   // one machine cycle is one core clock
   localparam int READ_PAGE_CYC = READ_PAGE_MC;
   localparam int VERIFY_PAGE_CYC = VERIFY_PAGE_MC;
   localparam int READ_BYTE_CYC = READ_BYTE_MC;
   localparam int WRITE_PAGE_CYC = WRITE_PAGE_US * CLK_MHZ;
   localparam int WRITE_BYTE_CYC = WRITE_BYTE_US * CLK_MHZ;
   localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
   localparam int UPD_WRITE_PAGE_CYC = UPD_WRITE_PAGE_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 20;

   // =====================================
   // register addresses in the special function space
   localparam logic [7:0] ADDR_DATA_ONE = 8'hBC;
   localparam logic [7:0] ADDR_DATA_TWO = 8'hBD;
   localparam logic [7:0] ADDR_DATA_THREE = 8'hBE;
   localparam logic [7:0] ADDR_DATA_FOUR = 8'hBF;
   localparam logic [7:0] ADDR_CMD = 8'hB9;
   localparam logic [7:0] ADDR_ADR_LOW = 8'hC6;
   localparam logic [7:0] ADDR_ADR_HIGH = 8'hC7;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // =====================================
   // command codes
   localparam logic [7:0] CMD_READ_PAGE = 8'h01;
   localparam logic [7:0] CMD_WRITE_PAGE = 8'h02;
   localparam logic [7:0] CMD_VERIFY_PAGE = 8'h04;
   localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
   localparam logic [7:0] CMD_READ_BYTE = 8'h81;
   localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
   localparam logic [7:0] CMD_LEAVE_UPDATE = 8'h0F;
   localparam logic [7:0] CMD_ENTER_UPDATE = 8'hF0;

   // =====================================
   // array geometry and limits
   localparam int DATA_BYTES = 4096;
   localparam logic [15:0] DATA_PAGE_LIMIT = 16'h0400;
   localparam logic [15:0] UPD_PAGE_LIMIT = 16'h00E0;
   localparam logic [15:0] UPD_BYTE_MAX = 16'hDFFF;
   localparam logic [15:0] UPD_ERASE_MASK = 16'hFFC0;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] LAST_INTERNAL_EXTENDED_RAM = 8'hFF;

   // program memory request
   typedef struct packed {
      logic we;
      logic erase_page;
      logic erase_all;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pm_req_t;

   typedef enum logic [1:0] {MODE_NORMAL, MODE_UPDATE} mode_t;
endpackage

// ### verilog/flash_data_memory_command_unit.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] data array is 1024 pages of four bytes, paged by address high and low
// [RULE2] four byte-wide holding registers carry one page to and from the array
// [RULE3] 8-bit command register; nine codes trigger read, write, erase, verify, mode
// [RULE4] 01H copies addressed data page into holding bytes; not in update mode
// [RULE5] 02H programs holding bytes into data page below 0400H; page pre-erased
// [RULE6] update 02H programs extended RAM bytes 0-255 into program page below E0H
// [RULE7] 04H compares holding bytes with page; command reads zero on match
// [RULE8] 05H erases data page, or 64-byte program page in update mode
// [RULE9] 06H erases whole data array, or whole 56-kbyte update region
// [RULE10] 81H reads one data byte up to 0FFFH into first holding byte
// [RULE11] 82H programs first holding byte at byte address, program up to DFFFH
// [RULE12] 0FH selects normal mode, commands act on data array
// [RULE13] F0H selects update mode, commands act on program memory
// [RULE14] reset leaves the unit in normal mode
// [RULE15] update mode reaches only the lower 56 kbytes of program memory
// [RULE16] software programs only erased bytes; erase clears whole pages
// [RULE17] software loads address, fills holding bytes, then writes command
// [RULE18] update timing: page write 15 ms, erases 2 ms, byte write 200 us
// [RULE19] operation starts at the command write; core stalls until done
// [RULE20] core takes no interrupts while busy; peripherals keep running
// [RULE21] setup software should erase the whole data array once
// [RULE22] normal mode stalls tens of cycles for reads, longer for writes, erases
// [RULE23] reserved or unimplemented codes start nothing and leave arrays unchanged
module flash_data_memory_command_unit #(
   parameter int WRITE_PAGE_CYCLES = flash_cmd_pkg::WRITE_PAGE_CYC,
   parameter int ERASE_CYCLES = flash_cmd_pkg::ERASE_CYC,
   parameter int UPD_WRITE_PAGE_CYCLES = flash_cmd_pkg::UPD_WRITE_PAGE_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // special function register access from the core
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // core control
   output logic core_stall,
   output logic irq_hold,
   output logic update_mode,
   // internal extended ram read port
   output logic [7:0] internal_extended_ram_addr,
   input wire logic [7:0] internal_extended_ram_rdata,
   // program memory request
   output flash_cmd_pkg::pm_req_t pm_req
);
   import flash_cmd_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} state_t;

   // =====================================
   // state
   state_t state_reg, state_next;
   mode_t mode_reg, mode_next;
   logic [7:0] data_reg [4];
   logic [7:0] data_next [4];
   logic [7:0] adr_high_reg, adr_high_next;
   logic [7:0] adr_low_reg, adr_low_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] idx_reg, idx_next;
   pm_req_t pm_reg, pm_next;
   logic [7:0] mem [DATA_BYTES];

   // array update request
   logic arr_erase_all;
   logic [3:0] arr_we;
   logic [9:0] arr_page;
   logic [7:0] arr_wdata [4];

   logic [15:0] adr;
   logic [9:0] page;
   logic [11:0] byte_adr;
   logic [3:0] miss;

   function automatic logic [CNT_W-1:0] cycles(input int n);
      cycles = n[CNT_W-1:0];
   endfunction

   assign adr = {adr_high_reg, adr_low_reg};
   assign page = adr[9:0]; // [RULE1]
   assign byte_adr = adr[11:0];

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         miss[i] = (mem[{page, i[1:0]}] != data_reg[i]);
      end
   end

   // =====================================
   // command sequencing
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      adr_high_next = adr_high_reg;
      adr_low_next = adr_low_reg;
      cmd_next = cmd_reg;
      cnt_next = cnt_reg;
      idx_next = idx_reg;
      for (int i = 0; i < 4; i++) begin
         data_next[i] = data_reg[i];
         arr_wdata[i] = ERASED_BYTE;
      end
      pm_next = '0;
      arr_erase_all = 1'b0;
      arr_we = 4'h0;
      arr_page = page;
      unique case (state_reg)
         ST_IDLE: begin
            if (sfr_wr) begin
               unique case (sfr_addr)
                  ADDR_DATA_ONE: data_next[0] = sfr_wdata; // [RULE2]
                  ADDR_DATA_TWO: data_next[1] = sfr_wdata;
                  ADDR_DATA_THREE: data_next[2] = sfr_wdata;
                  ADDR_DATA_FOUR: data_next[3] = sfr_wdata;
                  ADDR_ADR_HIGH: adr_high_next = sfr_wdata;
                  ADDR_ADR_LOW: adr_low_next = sfr_wdata;
                  ADDR_CMD: begin
                     cmd_next = sfr_wdata; // [RULE3]
                     state_next = ST_WAIT; // [RULE19]
                     cnt_next = '0;
                     if (mode_reg == MODE_NORMAL) begin
                        unique case (sfr_wdata)
                           CMD_READ_PAGE: begin
                              for (int i = 0; i < 4; i++) begin
                                 data_next[i] = mem[{page, i[1:0]}]; // [RULE4]
                              end
                              cnt_next = cycles(READ_PAGE_CYC); // [RULE22]
                           end
                           CMD_WRITE_PAGE: begin
                              if (adr < DATA_PAGE_LIMIT) begin // [RULE5]
                                 arr_we = 4'hF;
                                 for (int i = 0; i < 4; i++) begin
                                    arr_wdata[i] = mem[{page, i[1:0]}] & data_reg[i];
                                 end
                                 cnt_next = cycles(WRITE_PAGE_CYCLES); // [RULE22]
                              end else begin
                                 state_next = ST_IDLE; // [RULE23]
                              end
                           end
                           CMD_VERIFY_PAGE: begin
                              cmd_next = {4'h0, miss}; // [RULE7]
                              cnt_next = cycles(VERIFY_PAGE_CYC);
                           end
                           CMD_ERASE_PAGE: begin
                              arr_we = 4'hF; // [RULE8]
                              cnt_next = cycles(ERASE_CYCLES);
                           end
                           CMD_ERASE_ALL: begin
                              arr_erase_all = 1'b1; // [RULE9]
                              cnt_next = cycles(ERASE_CYCLES);
                           end
                           CMD_READ_BYTE: begin
                              data_next[0] = mem[byte_adr]; // [RULE10]
                              cnt_next = cycles(READ_BYTE_CYC);
                           end
                           CMD_WRITE_BYTE: begin
                              arr_page = byte_adr[11:2]; // [RULE11]
                              arr_we[byte_adr[1:0]] = 1'b1;
                              arr_wdata[byte_adr[1:0]] = mem[byte_adr] & data_reg[0];
                              cnt_next = cycles(WRITE_BYTE_CYC);
                           end
                           CMD_ENTER_UPDATE: mode_next = MODE_UPDATE; // [RULE13]
                           CMD_LEAVE_UPDATE: mode_next = MODE_NORMAL; // [RULE12]
                           default: state_next = ST_IDLE; // [RULE23]
                        endcase
                     end else begin
                        unique case (sfr_wdata)
                           CMD_WRITE_PAGE: begin
                              if (adr < UPD_PAGE_LIMIT) begin // [RULE6]
                                 idx_next = '0;
                                 state_next = ST_STREAM;
                                 cnt_next = cycles(UPD_WRITE_PAGE_CYCLES); // [RULE18]
                              end else begin
                                 state_next = ST_IDLE; // [RULE23]
                              end
                           end
                           CMD_ERASE_PAGE: begin
                              if (adr <= UPD_BYTE_MAX) begin // [RULE15]
                                 pm_next.erase_page = 1'b1; // [RULE8]
                                 pm_next.addr = adr & UPD_ERASE_MASK;
                                 cnt_next = cycles(ERASE_CYCLES); // [RULE18]
                              end else begin
                                 state_next = ST_IDLE; // [RULE23]
                              end
                           end
                           CMD_ERASE_ALL: begin
                              pm_next.erase_all = 1'b1; // [RULE9]
                              cnt_next = cycles(ERASE_CYCLES); // [RULE18]
                           end
                           CMD_WRITE_BYTE: begin
                              if (adr <= UPD_BYTE_MAX) begin // [RULE15]
                                 pm_next.we = 1'b1; // [RULE11]
                                 pm_next.addr = adr;
                                 pm_next.wdata = data_reg[0];
                                 cnt_next = cycles(WRITE_BYTE_CYC); // [RULE18]
                              end else begin
                                 state_next = ST_IDLE; // [RULE23]
                              end
                           end
                           CMD_ENTER_UPDATE: mode_next = MODE_UPDATE; // [RULE13]
                           CMD_LEAVE_UPDATE: mode_next = MODE_NORMAL; // [RULE12]
                           default: state_next = ST_IDLE; // [RULE23]
                        endcase
                     end
                  end
                  default: ;
               endcase
            end
         end
         ST_STREAM: begin
            // one extended ram byte per clock into the program page
            pm_next.we = 1'b1; // [RULE6]
            pm_next.addr = {adr_low_reg, idx_reg};
            pm_next.wdata = internal_extended_ram_rdata;
            idx_next = idx_reg + 8'h01;
            cnt_next = cnt_reg - 1'b1;
            if (idx_reg == LAST_INTERNAL_EXTENDED_RAM) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cnt_reg <= 1) begin
               state_next = ST_IDLE; // [RULE19]
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         mode_reg <= MODE_NORMAL; // [RULE14]
         adr_high_reg <= 8'h00;
         adr_low_reg <= 8'h00;
         cmd_reg <= CMD_RESET;
         cnt_reg <= '0;
         idx_reg <= 8'h00;
         pm_reg <= '0;
         for (int i = 0; i < 4; i++) begin
            data_reg[i] <= 8'h00;
         end
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         adr_high_reg <= adr_high_next;
         adr_low_reg <= adr_low_next;
         cmd_reg <= cmd_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         pm_reg <= pm_next;
         for (int i = 0; i < 4; i++) begin
            data_reg[i] <= data_next[i];
         end
      end
   end

   // =====================================
   // data array storage, programming only clears bits
   always_ff @(posedge clock) begin
      if (arr_erase_all) begin
         for (int j = 0; j < DATA_BYTES; j++) begin
            mem[j] <= ERASED_BYTE;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (arr_we[i]) begin
               mem[{arr_page, i[1:0]}] <= arr_wdata[i];
            end
         end
      end
   end

   // =====================================
   // read back and outputs
   always_comb begin
      unique case (sfr_addr)
         ADDR_DATA_ONE: sfr_rdata = data_reg[0];
         ADDR_DATA_TWO: sfr_rdata = data_reg[1];
         ADDR_DATA_THREE: sfr_rdata = data_reg[2];
         ADDR_DATA_FOUR: sfr_rdata = data_reg[3];
         ADDR_ADR_HIGH: sfr_rdata = adr_high_reg;
         ADDR_ADR_LOW: sfr_rdata = adr_low_reg;
         ADDR_CMD: sfr_rdata = cmd_reg; // [RULE7]
         default: sfr_rdata = 8'h00;
      endcase
   end

   assign core_stall = (state_reg != ST_IDLE); // [RULE19]
   assign irq_hold = (state_reg != ST_IDLE); // [RULE20]
   assign update_mode = (mode_reg == MODE_UPDATE);
   assign internal_extended_ram_addr = idx_reg;
   assign pm_req = pm_reg;
endmodule
`default_nettype wire
